// ===== logic/adc_cfg_pkg.sv
// Purpose: Shared constants and types of the converter configuration bank
// Assumes: 14-bit register addresses, 8-bit register data
// Notes: Reserved bits are stored as zero and read back as zero
package adc_cfg_pkg;

   localparam int ADDR_W = 14;
   localparam int DATA_W = 8;
   localparam int FRAME_BITS = 24;
   localparam int HEADER_BITS = 16;
   localparam int SAMPLE_W = 14;
   localparam int CHANNELS = 2;

   // Frame layout, MSB first
   localparam int FRAME_RW_POS = 15;
   localparam int FRAME_READOUT_POS = 14;
   localparam logic [4:0] LAST_HEADER_BIT = 5'h0f;
   localparam logic [4:0] LAST_FRAME_BIT = 5'h17;

   // Register addresses
   localparam logic [ADDR_W-1:0] DITHER_DISABLE_CTRL = 14'h0001;
   localparam logic [ADDR_W-1:0] LANE_ORDER_CTRL = 14'h0003;
   localparam logic [ADDR_W-1:0] LANE_SWAP_CTRL = 14'h0004;
   localparam logic [ADDR_W-1:0] LANE_COUNT_CTRL = 14'h0005;
   localparam logic [ADDR_W-1:0] PATTERN_AND_RESET_CTRL = 14'h0006;
   localparam logic [ADDR_W-1:0] OVERRANGE_MAP_CTRL = 14'h0007;
   localparam logic [ADDR_W-1:0] HIGH_IF_FIRST = 14'h041d;
   localparam logic [ADDR_W-1:0] CHOPPER_FIRST = 14'h0422;
   localparam logic [ADDR_W-1:0] EXT_DITHER_FIRST = 14'h0434;
   localparam logic [ADDR_W-1:0] PERF_FIRST = 14'h0439;
   localparam logic [ADDR_W-1:0] HIGH_IF_SECOND = 14'h051d;
   localparam logic [ADDR_W-1:0] CHOPPER_SECOND = 14'h0522;
   localparam logic [ADDR_W-1:0] EXT_DITHER_SECOND = 14'h0534;
   localparam logic [ADDR_W-1:0] PERF_SECOND = 14'h0539;
   localparam logic [ADDR_W-1:0] HIGH_IF_SHARED = 14'h0608;

   // Field positions
   localparam int DITHER_FIRST_LO = 4;
   localparam int DITHER_SECOND_LO = 2;
   localparam int LANE_BIT_POS = 0;
   localparam int PATTERN_EN_POS = 1;
   localparam int SW_RESET_POS = 0;
   localparam int OVR_BIT_POS = 0;
   localparam int HIGH_IF_BIT_POS = 1;
   localparam int CHOP_BIT_POS = 1;
   localparam int EXT_DITHER_HI = 5;
   localparam int EXT_DITHER_LO = 3;
   localparam int PERF_BIT_POS = 3;
   localparam int HIGH_IF_SHARED_LO = 6;
   localparam logic [1:0] FIELD_ALL_ONES = 2'h3;

   typedef struct packed {
      logic [1:0] ditherOffFirstChannel;
      logic [1:0] ditherOffSecondChannel;
      logic laneOrder;
      logic laneSwap;
      logic laneCountSelect;
      logic patternEn;
      logic overrangeOnBit0;
      logic highIfSelLow;
      logic highIfSelMid;
      logic [1:0] highIfShared;
      logic chopperOffFirstChannel;
      logic chopperOffSecondChannel;
      logic [1:0] extDitherFirst;
      logic [1:0] extDitherSecond;
      logic perfBitFirstChannel;
      logic perfBitSecondChannel;
   } cfg_type;

   localparam cfg_type CFG_RESET = '0;

   typedef struct packed {
      logic ditherOff;
      logic chopperOff;
      logic highIfOn;
      logic perfOn;
   } mode_type;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_HEADER = 2'b01,
      PH_DATA = 2'b10
   } phase_type;

endpackage

// ===== logic/sync_2ff.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes: Stage one is read only by stage two
`timescale 1ns/1ps
module sync_2ff #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1 <= '0;
         dout <= '0;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end

endmodule

// ===== logic/adc_output_config_regs.sv
// Purpose: Configuration bank and output formatting of a dual converter
// Assumes: Serial clock well below a quarter of clk_sys
// Notes: Frame is R/W, readout, 14 address bits, 8 data bits, MSB first
`timescale 1ns/1ps
//
// Contract
// - Dither off needs low and extended fields
// - Per-channel chopper disable at bit 1
// - High-IF needs both channel bits plus shared
// - First channel dither field bits 5-4
// - Second channel dither field bits 3-2
// - Lane order: split halves or even/odd
// - Lane swap only in two-lane mode
// - Lane count: zero two lanes, one single
// - Pattern enable replaces samples with pattern
// - Software reset restores defaults, self-clears
// - Software reset bit is write-only one-shot
// - Overrange mapping puts overrange on bit 0; code skips it while pattern enable is set
// - Software reset works without the reset pin
module adc_output_config_regs #(
   parameter int SAMPLE_W = adc_cfg_pkg::SAMPLE_W
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Serial programming pins
   input wire logic senN,
   input wire logic sclk,
   input wire logic sdio,
   output logic sdout,
   output logic sdoutOe,
   // Sample path, same clock
   input wire logic [SAMPLE_W-1:0] sample [adc_cfg_pkg::CHANNELS],
   input wire logic overrange [adc_cfg_pkg::CHANNELS],
   input wire logic [SAMPLE_W-1:0] pattern [adc_cfg_pkg::CHANNELS],
   output logic [SAMPLE_W-1:0] laneWord0 [adc_cfg_pkg::CHANNELS],
   output logic [SAMPLE_W/2-1:0] laneWord1 [adc_cfg_pkg::CHANNELS],
   // Configuration view
   output adc_cfg_pkg::cfg_type cfg,
   output adc_cfg_pkg::mode_type mode [adc_cfg_pkg::CHANNELS],
   output logic swResetPulse
);

   localparam int HALF = SAMPLE_W / 2;

   if (SAMPLE_W < 2 || SAMPLE_W % 2 != 0) begin : g_check
      $error("SAMPLE_W must be even and at least 2");
   end

   logic selS, sclkS, sdioS, sclkPrev;
   logic sclkRise, sclkFall, frameActive;

   sync_2ff #(.WIDTH(3)) u_sync (
      .clk(clk_sys),
      .rst(rst),
      // Select synced active high, so reset reads as no frame
      .din({~senN, sclk, sdio}),
      .dout({selS, sclkS, sdioS})
   );

   assign frameActive = selS;
   assign sclkRise = frameActive & sclkS & ~sclkPrev;
   assign sclkFall = frameActive & ~sclkS & sclkPrev;

   // Serial frame state
   adc_cfg_pkg::phase_type phase, next_phase;
   logic [4:0] bitCnt, next_bitCnt;
   logic [adc_cfg_pkg::FRAME_BITS-2:0] shiftIn, next_shiftIn;
   logic [7:0] shiftOut, next_shiftOut;
   logic isRead, next_isRead;
   logic next_sdout, next_sdoutOe;
   logic [adc_cfg_pkg::FRAME_BITS-1:0] frame;
   logic [adc_cfg_pkg::HEADER_BITS-1:0] header;

   // Register state
   adc_cfg_pkg::cfg_type next_cfg;
   logic next_swResetPulse;

   function automatic logic [7:0] readReg(
      input logic [adc_cfg_pkg::ADDR_W-1:0] addr,
      input adc_cfg_pkg::cfg_type c
   );
      logic [7:0] r;
      r = 8'h00;
      case (addr)
         adc_cfg_pkg::DITHER_DISABLE_CTRL: begin
            r[adc_cfg_pkg::DITHER_FIRST_LO +: 2] = c.ditherOffFirstChannel;
            r[adc_cfg_pkg::DITHER_SECOND_LO +: 2] = c.ditherOffSecondChannel;
         end
         adc_cfg_pkg::LANE_ORDER_CTRL:
            r[adc_cfg_pkg::LANE_BIT_POS] = c.laneOrder;
         adc_cfg_pkg::LANE_SWAP_CTRL:
            r[adc_cfg_pkg::LANE_BIT_POS] = c.laneSwap;
         adc_cfg_pkg::LANE_COUNT_CTRL:
            r[adc_cfg_pkg::LANE_BIT_POS] = c.laneCountSelect;
         // Reset bit always reads zero
         adc_cfg_pkg::PATTERN_AND_RESET_CTRL:
            r[adc_cfg_pkg::PATTERN_EN_POS] = c.patternEn;
         adc_cfg_pkg::OVERRANGE_MAP_CTRL:
            r[adc_cfg_pkg::OVR_BIT_POS] = c.overrangeOnBit0;
         adc_cfg_pkg::HIGH_IF_FIRST:
            r[adc_cfg_pkg::HIGH_IF_BIT_POS] = c.highIfSelLow;
         adc_cfg_pkg::HIGH_IF_SECOND:
            r[adc_cfg_pkg::HIGH_IF_BIT_POS] = c.highIfSelMid;
         adc_cfg_pkg::HIGH_IF_SHARED:
            r[adc_cfg_pkg::HIGH_IF_SHARED_LO +: 2] = c.highIfShared;
         adc_cfg_pkg::CHOPPER_FIRST:
            r[adc_cfg_pkg::CHOP_BIT_POS] = c.chopperOffFirstChannel;
         adc_cfg_pkg::CHOPPER_SECOND:
            r[adc_cfg_pkg::CHOP_BIT_POS] = c.chopperOffSecondChannel;
         adc_cfg_pkg::EXT_DITHER_FIRST: begin
            r[adc_cfg_pkg::EXT_DITHER_HI] = c.extDitherFirst[1];
            r[adc_cfg_pkg::EXT_DITHER_LO] = c.extDitherFirst[0];
         end
         adc_cfg_pkg::EXT_DITHER_SECOND: begin
            r[adc_cfg_pkg::EXT_DITHER_HI] = c.extDitherSecond[1];
            r[adc_cfg_pkg::EXT_DITHER_LO] = c.extDitherSecond[0];
         end
         adc_cfg_pkg::PERF_FIRST:
            r[adc_cfg_pkg::PERF_BIT_POS] = c.perfBitFirstChannel;
         adc_cfg_pkg::PERF_SECOND:
            r[adc_cfg_pkg::PERF_BIT_POS] = c.perfBitSecondChannel;
         default:
            r = 8'h00;
      endcase
      return r;
   endfunction

   assign frame = {shiftIn, sdioS};
   assign header = {shiftIn[adc_cfg_pkg::HEADER_BITS-2:0], sdioS};

   // Frame sequencing and register writes
   always_comb begin
      logic [adc_cfg_pkg::ADDR_W-1:0] wAddr;
      logic [7:0] d;
      wAddr = frame[adc_cfg_pkg::DATA_W +: adc_cfg_pkg::ADDR_W];
      d = frame[7:0];
      next_phase = phase;
      next_bitCnt = bitCnt;
      next_shiftIn = shiftIn;
      next_shiftOut = shiftOut;
      next_isRead = isRead;
      next_sdout = sdout;
      next_sdoutOe = sdoutOe;
      next_cfg = cfg;
      next_swResetPulse = 1'b0;
      if (!frameActive) begin
         next_phase = adc_cfg_pkg::PH_IDLE;
         next_bitCnt = 5'h00;
         next_isRead = 1'b0;
         next_sdoutOe = 1'b0;
         next_sdout = 1'b0;
      end else begin
         if (phase == adc_cfg_pkg::PH_IDLE) begin
            next_phase = adc_cfg_pkg::PH_HEADER;
         end
         if (sclkRise) begin
            next_shiftIn = frame[adc_cfg_pkg::FRAME_BITS-2:0];
            next_bitCnt = bitCnt + 5'h01;
            case (phase)
               adc_cfg_pkg::PH_IDLE,
               adc_cfg_pkg::PH_HEADER: begin
                  if (bitCnt == adc_cfg_pkg::LAST_HEADER_BIT) begin
                     next_phase = adc_cfg_pkg::PH_DATA;
                     next_isRead = header[adc_cfg_pkg::FRAME_RW_POS];
                     next_shiftOut = readReg(
                        header[adc_cfg_pkg::ADDR_W-1:0], cfg);
                  end
               end
               adc_cfg_pkg::PH_DATA: begin
                  if (bitCnt == adc_cfg_pkg::LAST_FRAME_BIT) begin
                     next_phase = adc_cfg_pkg::PH_IDLE;
                     next_bitCnt = 5'h00;
                     next_isRead = 1'b0;
                     if (!isRead) begin
                        case (wAddr)
                           adc_cfg_pkg::DITHER_DISABLE_CTRL: begin
                              next_cfg.ditherOffFirstChannel =
                                 d[adc_cfg_pkg::DITHER_FIRST_LO +: 2];
                              next_cfg.ditherOffSecondChannel =
                                 d[adc_cfg_pkg::DITHER_SECOND_LO +: 2];
                           end
                           adc_cfg_pkg::LANE_ORDER_CTRL:
                              next_cfg.laneOrder =
                                 d[adc_cfg_pkg::LANE_BIT_POS];
                           adc_cfg_pkg::LANE_SWAP_CTRL:
                              next_cfg.laneSwap =
                                 d[adc_cfg_pkg::LANE_BIT_POS];
                           adc_cfg_pkg::LANE_COUNT_CTRL:
                              next_cfg.laneCountSelect =
                                 d[adc_cfg_pkg::LANE_BIT_POS];
                           adc_cfg_pkg::PATTERN_AND_RESET_CTRL: begin
                              next_cfg.patternEn =
                                 d[adc_cfg_pkg::PATTERN_EN_POS];
                              if (d[adc_cfg_pkg::SW_RESET_POS]) begin
                                 next_cfg = adc_cfg_pkg::CFG_RESET;
                                 next_swResetPulse = 1'b1;
                              end
                           end
                           adc_cfg_pkg::OVERRANGE_MAP_CTRL:
                              next_cfg.overrangeOnBit0 =
                                 d[adc_cfg_pkg::OVR_BIT_POS];
                           adc_cfg_pkg::HIGH_IF_FIRST:
                              next_cfg.highIfSelLow =
                                 d[adc_cfg_pkg::HIGH_IF_BIT_POS];
                           adc_cfg_pkg::HIGH_IF_SECOND:
                              next_cfg.highIfSelMid =
                                 d[adc_cfg_pkg::HIGH_IF_BIT_POS];
                           adc_cfg_pkg::HIGH_IF_SHARED:
                              next_cfg.highIfShared =
                                 d[adc_cfg_pkg::HIGH_IF_SHARED_LO +: 2];
                           adc_cfg_pkg::CHOPPER_FIRST:
                              next_cfg.chopperOffFirstChannel =
                                 d[adc_cfg_pkg::CHOP_BIT_POS];
                           adc_cfg_pkg::CHOPPER_SECOND:
                              next_cfg.chopperOffSecondChannel =
                                 d[adc_cfg_pkg::CHOP_BIT_POS];
                           adc_cfg_pkg::EXT_DITHER_FIRST:
                              next_cfg.extDitherFirst =
                                 {d[adc_cfg_pkg::EXT_DITHER_HI],
                                  d[adc_cfg_pkg::EXT_DITHER_LO]};
                           adc_cfg_pkg::EXT_DITHER_SECOND:
                              next_cfg.extDitherSecond =
                                 {d[adc_cfg_pkg::EXT_DITHER_HI],
                                  d[adc_cfg_pkg::EXT_DITHER_LO]};
                           adc_cfg_pkg::PERF_FIRST:
                              next_cfg.perfBitFirstChannel =
                                 d[adc_cfg_pkg::PERF_BIT_POS];
                           adc_cfg_pkg::PERF_SECOND:
                              next_cfg.perfBitSecondChannel =
                                 d[adc_cfg_pkg::PERF_BIT_POS];
                           default: begin
                           end
                        endcase
                     end
                  end
               end
               default:
                  next_phase = adc_cfg_pkg::PH_IDLE;
            endcase
         end
         // Readback byte leaves on falling serial clock edges
         if (sclkFall && phase == adc_cfg_pkg::PH_DATA && isRead) begin
            next_sdout = shiftOut[7];
            next_sdoutOe = 1'b1;
            next_shiftOut = {shiftOut[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclkPrev <= 1'b0;
         phase <= adc_cfg_pkg::PH_IDLE;
         bitCnt <= 5'h00;
         shiftIn <= '0;
         shiftOut <= 8'h00;
         isRead <= 1'b0;
         sdout <= 1'b0;
         sdoutOe <= 1'b0;
         cfg <= adc_cfg_pkg::CFG_RESET;
         swResetPulse <= 1'b0;
      end else begin
         sclkPrev <= sclkS;
         phase <= next_phase;
         bitCnt <= next_bitCnt;
         shiftIn <= next_shiftIn;
         shiftOut <= next_shiftOut;
         isRead <= next_isRead;
         sdout <= next_sdout;
         sdoutOe <= next_sdoutOe;
         cfg <= next_cfg;
         swResetPulse <= next_swResetPulse;
      end
   end

   // Per-channel mode decode and output formatting
   adc_cfg_pkg::mode_type next_mode [adc_cfg_pkg::CHANNELS];
   logic [SAMPLE_W-1:0] next_laneWord0 [adc_cfg_pkg::CHANNELS];
   logic [HALF-1:0] next_laneWord1 [adc_cfg_pkg::CHANNELS];

   always_comb begin
      logic [SAMPLE_W-1:0] w;
      logic [HALF-1:0] l0, l1;
      logic [1:0] low, ext;
      logic highIfAll;
      w = '0;
      l0 = '0;
      l1 = '0;
      low = 2'h0;
      ext = 2'h0;
      highIfAll = cfg.highIfSelLow & cfg.highIfSelMid &
         (cfg.highIfShared == adc_cfg_pkg::FIELD_ALL_ONES);
      for (int ch = 0; ch < adc_cfg_pkg::CHANNELS; ch++) begin
         low = (ch == 0) ? cfg.ditherOffFirstChannel
                         : cfg.ditherOffSecondChannel;
         ext = (ch == 0) ? cfg.extDitherFirst : cfg.extDitherSecond;
         next_mode[ch].ditherOff =
            (low == adc_cfg_pkg::FIELD_ALL_ONES) &&
            (ext == adc_cfg_pkg::FIELD_ALL_ONES);
         next_mode[ch].chopperOff = (ch == 0) ?
            cfg.chopperOffFirstChannel : cfg.chopperOffSecondChannel;
         next_mode[ch].highIfOn = highIfAll;
         next_mode[ch].perfOn = (ch == 0) ?
            cfg.perfBitFirstChannel : cfg.perfBitSecondChannel;
         w = cfg.patternEn ? pattern[ch] : sample[ch];
         if (cfg.overrangeOnBit0 && !cfg.patternEn) begin
            w[0] = overrange[ch];
         end
         for (int i = 0; i < HALF; i++) begin
            if (cfg.laneOrder) begin
               l0[i] = w[2*i];
               l1[i] = w[2*i+1];
            end else begin
               l0[i] = w[i];
               l1[i] = w[HALF+i];
            end
         end
         if (cfg.laneCountSelect) begin
            next_laneWord0[ch] = w;
            next_laneWord1[ch] = '0;
         end else if (cfg.laneSwap) begin
            next_laneWord0[ch] = {{(SAMPLE_W-HALF){1'b0}}, l1};
            next_laneWord1[ch] = l0;
         end else begin
            next_laneWord0[ch] = {{(SAMPLE_W-HALF){1'b0}}, l0};
            next_laneWord1[ch] = l1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int ch = 0; ch < adc_cfg_pkg::CHANNELS; ch++) begin
            mode[ch] <= '0;
            laneWord0[ch] <= '0;
            laneWord1[ch] <= '0;
         end
      end else begin
         for (int ch = 0; ch < adc_cfg_pkg::CHANNELS; ch++) begin
            mode[ch] <= next_mode[ch];
            laneWord0[ch] <= next_laneWord0[ch];
            laneWord1[ch] <= next_laneWord1[ch];
         end
      end
   end

endmodule

// ===== test/adc_output_config_regs_asserts.sv
// Purpose: Port checks of the configuration bank
// Assumes: Mode and lane words follow cfg one clock later
// Notes: Bound to every instance of the bank
`timescale 1ns/1ps
module adc_output_config_regs_checker #(
   parameter int SAMPLE_W = 14
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Sample path
   input wire logic [SAMPLE_W-1:0] sample [adc_cfg_pkg::CHANNELS],
   input wire logic overrange [adc_cfg_pkg::CHANNELS],
   input wire logic [SAMPLE_W-1:0] pattern [adc_cfg_pkg::CHANNELS],
   input wire logic [SAMPLE_W-1:0] laneWord0 [adc_cfg_pkg::CHANNELS],
   input wire logic [SAMPLE_W/2-1:0] laneWord1 [adc_cfg_pkg::CHANNELS],
   // Configuration view
   input wire adc_cfg_pkg::cfg_type cfg,
   input wire adc_cfg_pkg::mode_type mode [adc_cfg_pkg::CHANNELS],
   input wire logic swResetPulse
);
   // Masks the first edge after reset, when outputs still hold zero
   logic live;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         live <= 1'b0;
      end else begin
         live <= 1'b1;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_swreset_clears: assert property (swResetPulse |-> cfg == '0)
      else $error("cfg not cleared by software reset");
   a_pulse_once: assert property (swResetPulse |=> !swResetPulse)
      else $error("software reset pulse too long");
   a_dither_first: assert property (live |->
      mode[0].ditherOff == ($past(cfg.ditherOffFirstChannel) == 2'h3
      && $past(cfg.extDitherFirst) == 2'h3))
      else $error("first channel dither decode wrong");
   a_dither_second: assert property (live |->
      mode[1].ditherOff == ($past(cfg.ditherOffSecondChannel) == 2'h3
      && $past(cfg.extDitherSecond) == 2'h3))
      else $error("second channel dither decode wrong");
   a_chopper_map: assert property (live |->
      mode[0].chopperOff == $past(cfg.chopperOffFirstChannel)
      && mode[1].chopperOff == $past(cfg.chopperOffSecondChannel))
      else $error("chopper decode wrong");
   a_high_if: assert property (live |->
      mode[0].highIfOn == mode[1].highIfOn
      && mode[1].highIfOn == $past(cfg.highIfSelLow && cfg.highIfSelMid
      && cfg.highIfShared == 2'h3))
      else $error("high-IF decode wrong");
   a_single_lane: assert property (live && $past(cfg.laneCountSelect
      && !cfg.patternEn && !cfg.overrangeOnBit0) |->
      laneWord0[0] == $past(sample[0]) && laneWord1[0] == '0)
      else $error("single lane word wrong");
   a_pattern_sel: assert property (live && $past(cfg.patternEn
      && cfg.laneCountSelect) |-> laneWord0[1] == $past(pattern[1]))
      else $error("pattern not selected");
   a_ovr_bit0: assert property (live && $past(cfg.overrangeOnBit0
      && cfg.laneCountSelect && !cfg.patternEn) |->
      laneWord0[0][0] == $past(overrange[0]))
      else $error("overrange not on bit 0");
   a_split_halves: assert property (live && $past(!cfg.laneCountSelect
      && !cfg.laneOrder && !cfg.laneSwap && !cfg.patternEn) |->
      laneWord1[1] == $past(sample[1][SAMPLE_W-1:SAMPLE_W/2]))
      else $error("upper half not on lane 1");
   a_swap_lanes: assert property (live && $past(!cfg.laneCountSelect
      && !cfg.laneOrder && cfg.laneSwap && !cfg.patternEn
      && !cfg.overrangeOnBit0) |->
      laneWord1[1] == $past(sample[1][SAMPLE_W/2-1:0]))
      else $error("lanes not swapped");
endmodule
bind adc_output_config_regs adc_output_config_regs_checker #(
   .SAMPLE_W(SAMPLE_W)
) u_checker (
   .clk_sys(clk_sys),
   .rst(rst),
   .sample(sample),
   .overrange(overrange),
   .pattern(pattern),
   .laneWord0(laneWord0),
   .laneWord1(laneWord1),
   .cfg(cfg),
   .mode(mode),
   .swResetPulse(swResetPulse)
);

// ===== test/serial_ctl_model.sv
// Purpose: External controller on the serial programming pins
// Assumes: Each sclk phase spans several clk_sys cycles
// Notes: Data byte is sent as given by the caller
`timescale 1ns/1ps
module serial_ctl_model (
   // Clock
   input wire logic clk_sys,
   // Serial pins
   output logic senN,
   output logic sclk,
   output logic sdio,
   input wire logic sdout
);
   localparam int HALF = 4;
   initial begin
      senN = 1'b1;
      sclk = 1'b0;
      sdio = 1'b0;
   end
   // One frame MSB first; read bits latched on sclk rise
   task automatic frame(input logic rw, input logic [13:0] addr,
         input logic [7:0] data, output logic [7:0] rd);
      logic [23:0] word;
      word = {rw, rw, addr, data};
      rd = 8'h00;
      @(posedge clk_sys);
      senN <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         repeat (HALF) @(posedge clk_sys);
         sdio <= word[i];
         repeat (HALF) @(posedge clk_sys);
         sclk <= 1'b1;
         if (i < 8) begin
            rd[i] = sdout;
         end
         repeat (HALF) @(posedge clk_sys);
         sclk <= 1'b0;
      end
      repeat (HALF) @(posedge clk_sys);
      senN <= 1'b1;
      sdio <= ~word[0];
      repeat (HALF) @(posedge clk_sys);
   endtask
endmodule

// ===== test/adc_output_config_regs_tb_top.sv
// Purpose: Self-checking bench of the configuration bank
// Assumes: Controller model drives the serial pins
// Notes: Lane expectations computed from register settings
`timescale 1ns/1ps
module adc_output_config_regs_tb_top;
   localparam logic [13:0] MA [10] = '{14'h0001, 14'h0434, 14'h0534,
      14'h0422, 14'h0522, 14'h041d, 14'h051d, 14'h0608, 14'h0439, 14'h0539};
   localparam logic [7:0] MD [10] = '{8'h3c, 8'h28, 8'h28, 8'h02, 8'h02,
      8'h02, 8'h02, 8'hc0, 8'h08, 8'h08};
   localparam logic [7:0] ME [10] = '{8'h00, 8'h80, 8'h88, 8'hc8, 8'hcc,
      8'hcc, 8'hcc, 8'hee, 8'hfe, 8'hff};
   localparam logic [13:0] RA [6] = '{14'h0001, 14'h0003, 14'h0004,
      14'h0005, 14'h0006, 14'h0007};
   localparam logic [7:0] RV [6] = '{8'h3c, 8'h01, 8'h01, 8'h01, 8'h02,
      8'h01};
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic senN, sclk, sdio, sdout, sdoutOe, swResetPulse;
   logic [13:0] sample [2];
   logic overrange [2];
   logic [13:0] pattern [2];
   logic [13:0] laneWord0 [2];
   logic [6:0] laneWord1 [2];
   adc_cfg_pkg::cfg_type cfg;
   adc_cfg_pkg::mode_type mode [2];
   int failures = 0;
   int samplesChecked = 0;
   int pulses = 0;
   int oeCycles = 0;
   always #20 clk_sys = ~clk_sys;
   always @(negedge clk_sys) begin
      if (swResetPulse === 1'b1) begin
         pulses++;
      end
      if (sdoutOe === 1'b1) begin
         oeCycles++;
      end
   end
   serial_ctl_model ctl (.clk_sys(clk_sys), .senN(senN), .sclk(sclk),
      .sdio(sdio), .sdout(sdout));
   adc_output_config_regs dut (.clk_sys(clk_sys), .rst(rst), .senN(senN),
      .sclk(sclk), .sdio(sdio), .sdout(sdout), .sdoutOe(sdoutOe),
      .sample(sample), .overrange(overrange), .pattern(pattern),
      .laneWord0(laneWord0), .laneWord1(laneWord1), .cfg(cfg),
      .mode(mode), .swResetPulse(swResetPulse));
   task automatic checkVal(input logic [31:0] got, input logic [31:0] exp,
         input string what);
      samplesChecked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      logic [7:0] r;
      ctl.frame(1'b0, a, d, r);
   endtask
   task automatic rd(input logic [13:0] a, output logic [7:0] r);
      ctl.frame(1'b1, a, 8'h00, r);
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", samplesChecked, failures);
      if (failures == 0 && samplesChecked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic testRegs();
      logic [7:0] r;
      for (int i = 0; i < 6; i++) begin
         rd(RA[i], r);
         checkVal(32'(r), 32'h0, "reset value");
         oeCycles = 0;
         wr(RA[i], RV[i]);
         checkVal(32'(oeCycles), 32'h0, "oe in write");
         rd(RA[i], r);
         checkVal(32'(r), 32'(RV[i]), "readback");
         checkVal(32'(oeCycles > 0), 32'h1, "oe in read");
         checkVal(32'(sdoutOe), 32'h0, "oe after read");
      end
      wr(14'h0002, 8'h5a);
      rd(14'h0002, r);
      checkVal(32'(r), 32'h0, "unmapped");
   endtask
   task automatic testModes();
      logic [7:0] r;
      for (int i = 0; i < 10; i++) begin
         wr(MA[i], MD[i]);
         @(negedge clk_sys);
         checkVal(32'({mode[0], mode[1]}), 32'(ME[i]), "mode");
         rd(MA[i], r);
         checkVal(32'(r), 32'(MD[i]), "mode readback");
      end
   endtask
   task automatic testSwReset();
      logic [7:0] r;
      pulses = 0;
      wr(14'h0006, 8'h03);
      @(negedge clk_sys);
      checkVal(32'(pulses), 32'h1, "reset pulses");
      checkVal(32'(cfg), 32'h0, "cfg after reset");
      checkVal(32'({mode[0], mode[1]}), 32'h0, "mode after reset");
      rd(14'h0006, r);
      checkVal(32'(r), 32'h0, "reset bit");
   endtask
   function automatic void expLanes(input int c, input logic [4:0] k,
         output logic [13:0] l0, output logic [6:0] l1);
      logic [13:0] w;
      w = k[3] ? pattern[c] : sample[c];
      if (k[4] && !k[3]) begin
         w[0] = overrange[c];
      end
      l0 = 14'h0000;
      l1 = 7'h00;
      if (k[2]) begin
         l0 = w;
      end else begin
         for (int i = 0; i < 7; i++) begin
            l0[i] = k[0] ? w[2*i] : w[i];
            l1[i] = k[0] ? w[2*i+1] : w[i+7];
         end
         if (k[1]) begin
            {l0[6:0], l1} = {l1, l0[6:0]};
         end
      end
   endfunction
   task automatic testLanes();
      logic [13:0] e0;
      logic [6:0] e1;
      for (int k = 0; k < 32; k++) begin
         wr(14'h0003, {7'h00, k[0]});
         wr(14'h0004, {7'h00, k[1]});
         wr(14'h0005, {7'h00, k[2]});
         wr(14'h0006, {6'h00, k[3], 1'b0});
         wr(14'h0007, {7'h00, k[4]});
         @(posedge clk_sys);
         sample[0] <= 14'h2a5c ^ 14'(k);
         sample[1] <= 14'h1337 ^ 14'(k << 7);
         repeat (2) @(posedge clk_sys);
         @(negedge clk_sys);
         for (int c = 0; c < 2; c++) begin
            expLanes(c, 5'(k), e0, e1);
            checkVal(32'(laneWord0[c]), 32'(e0), "lane0");
            checkVal(32'(laneWord1[c]), 32'(e1), "lane1");
         end
      end
   endtask
   initial begin
      sample = '{14'h2a5c, 14'h1337};
      overrange = '{1'b1, 1'b0};
      pattern = '{14'h0f0f, 14'h3c96};
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      testRegs();
      testModes();
      testSwReset();
      testLanes();
      print_verdict();
   end
   initial begin
      repeat (90000) @(posedge clk_sys);
      failures++;
      $display("[FAIL] %0t run did not finish", $time);
      print_verdict();
   end
endmodule
